// *** hw/hsp_device.sv ***
// Purpose: Module end of the host serial port with its receive and transmit buffers.
// Assumes: Power-of-two depths; receive depth above CTS_GO_FREE.
// Notes: A radio payload gives its length on its first byte.
`timescale 1ns/100ps

////////////////////////////////////////////////////////////////////////////////
// How it works
// - Host idles data-in high between characters.
// - Start low, eight bits LSB first, stop high.
// - Default format eight bits, no parity, one stop.
// - Both ends share baud, parity and framing settings.
// - Module UART times bits and checks parity.
// - Every received character enters the receive buffer unless it is full.
// - No draining while radio reception continues.
// - Draining stalls for routing, retries and broadcasts.
// - Bulk senders should honour clear-to-send.
// - Radio payloads queue then leave on data-out.
// - Payload larger than free space dropped whole.
// - Clear-to-send active low output, else gpio 7.
// - Request-to-send active low input, else gpio 6.
// - Sleep request input from host, else gpio 8.
// - Awake status output, else gpio 9.
// - Association indicator output, else gpio 5.
// - Button input low means pressed.
// - Clear-to-send high at 17 free, low at 34.
// - Request-to-send high holds transmit buffer data.
module hsp_device import hsp_pkg::*; #(
    parameter int BAUD = DEF_BAUD,
    parameter int RX_DEPTH = 64,
    parameter int TX_DEPTH = 128
) (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic ce,
    hsp_link_if.dev link,
    input wire hsp_parity_t parity_mode,
    input wire logic cts_flow_enable_cmd,
    input wire logic rts_flow_enable_cmd,
    input wire logic status_pin_enable,
    input wire logic assoc_pin_enable,
    output logic [7:0] rxb_data,
    output logic rxb_valid,
    input wire logic rxb_ready,
    input wire logic radio_rx_active,
    input wire logic route_busy,
    input wire logic [7:0] pl_data,
    input wire logic pl_valid,
    input wire logic pl_first,
    input wire logic [$clog2(TX_DEPTH+1)-1:0] pl_len,
    output logic pl_ready,
    output logic pl_dropped,
    output logic rx_overflow,
    output logic parity_err,
    output logic frame_err,
    input wire logic awake,
    input wire logic associated,
    input wire logic gpio_line_5,
    input wire logic gpio_line_7,
    input wire logic gpio_line_9,
    output logic gpio_line_6,
    output logic gpio_line_8,
    output logic sleep_requested,
    output logic button_pressed
);
    localparam int CPB = CLK_HZ / BAUD;
    localparam int RAW = $clog2(RX_DEPTH);
    localparam int RCW = $clog2(RX_DEPTH + 1);
    localparam int TAW = $clog2(TX_DEPTH);
    localparam int TCW = $clog2(TX_DEPTH + 1);
    localparam logic [RCW-1:0] RX_FULL = RCW'(RX_DEPTH);
    localparam logic [TCW-1:0] TX_FULL = TCW'(TX_DEPTH);
    localparam logic [RCW-1:0] STOP_FREE = RCW'(CTS_STOP_FREE);
    localparam logic [RCW-1:0] GO_FREE = RCW'(CTS_GO_FREE);
    localparam int NPIN = 3;

    ////////////////////////////////////////////////////////////////////////////
    // Host pins pass three flip-flops.
    logic [NPIN-1:0] pin_raw;
    logic [NPIN-1:0] pin_lvl;
    logic [2:0] sync_q [NPIN];
    wire rts_lvl = pin_lvl[0];
    wire sleep_lvl = pin_lvl[1];
    wire btn_lvl = pin_lvl[2];

    assign pin_raw = {link.btn_n, link.sleep_rq, link.rts_n};

    for (genvar i = 0; i < NPIN; i++) begin : g_sync
        always_ff @(posedge ref_clk) begin
            if (!rst_n) begin
                sync_q[i] <= SYNC_IDLE;
                pin_lvl[i] <= LINE_IDLE;
            end else if (ce) begin
                sync_q[i] <= {sync_q[i][1:0], pin_raw[i]};
                if (sync_q[i][1] == sync_q[i][2]) begin
                    pin_lvl[i] <= sync_q[i][2];
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Serial engine, same as the host's.
    logic [7:0] u_rx_data;
    logic u_rx_valid, u_par_err, u_frm_err;
    logic u_tx_ready;
    logic [7:0] tx_mem [TX_DEPTH];
    logic [TAW-1:0] twr, trd;
    logic [TCW-1:0] tcount;
    wire rts_hold = rts_flow_enable_cmd && (rts_lvl != FLOW_GO);
    wire u_tx_valid = (tcount != '0) && !rts_hold;

    hsp_uart #(.CLKS_PER_BIT(CPB)) u_uart (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .ce(ce),
        .parity_mode(parity_mode),
        .rx_pin(link.din),
        .tx_pin(link.dout),
        .tx_data(tx_mem[trd]),
        .tx_valid(u_tx_valid),
        .tx_ready(u_tx_ready),
        .rx_data(u_rx_data),
        .rx_valid(u_rx_valid),
        .rx_parity_err(u_par_err),
        .rx_frame_err(u_frm_err)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Receive buffer; a character meeting a full buffer is lost and reported.
    logic [7:0] rx_mem [RX_DEPTH];
    logic [RAW-1:0] rwr, rrd;
    logic [RCW-1:0] rcount;
    logic cts_hold;
    wire [RCW-1:0] rfree = RX_FULL - rcount;
    wire rx_push = u_rx_valid && (rcount != RX_FULL);
    wire drain_ok = !radio_rx_active && !route_busy;
    wire rx_pop = rxb_valid && rxb_ready;

    assign rxb_valid = (rcount != '0) && drain_ok;
    assign rxb_data = rx_mem[rrd];

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            rwr <= '0;
            rrd <= '0;
            rcount <= '0;
        end else if (ce) begin
            if (rx_push) begin
                rx_mem[rwr] <= u_rx_data;
                rwr <= rwr + 1'b1;
            end
            if (rx_pop) begin
                rrd <= rrd + 1'b1;
            end
            rcount <= rcount + RCW'(rx_push) - RCW'(rx_pop);
        end
    end

    // Hysteresis stops the flow pin chattering.
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            cts_hold <= 1'b0;
        end else if (ce) begin
            if (rfree <= STOP_FREE) begin
                cts_hold <= 1'b1;
            end else if (rfree >= GO_FREE) begin
                cts_hold <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Transmit buffer. Room is judged on the first byte only; draining only
    // frees space, so a kept payload never runs short.
    logic keep_pl;
    wire [TCW-1:0] tfree = TX_FULL - tcount;
    wire fits = (pl_len <= tfree);
    wire keep_now = pl_first ? fits : keep_pl;
    wire tx_push = pl_valid && pl_ready && keep_now;
    wire tx_pop = u_tx_valid && u_tx_ready;

    assign pl_ready = ce;

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            twr <= '0;
            trd <= '0;
            tcount <= '0;
            keep_pl <= 1'b0;
        end else if (ce) begin
            if (pl_valid && pl_first) begin
                keep_pl <= fits;
            end
            if (tx_push) begin
                tx_mem[twr] <= pl_data;
                twr <= twr + 1'b1;
            end
            if (tx_pop) begin
                trd <= trd + 1'b1;
            end
            tcount <= tcount + TCW'(tx_push) - TCW'(tx_pop);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Registered pulses and pin outputs.
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            pl_dropped <= 1'b0;
            rx_overflow <= 1'b0;
            parity_err <= 1'b0;
            frame_err <= 1'b0;
            link.cts_n <= LINE_IDLE;
            link.on_sleep <= 1'b0;
            link.assoc <= 1'b0;
            gpio_line_6 <= LINE_IDLE;
            gpio_line_8 <= LINE_IDLE;
            sleep_requested <= 1'b0;
            button_pressed <= 1'b0;
        end else if (ce) begin
            pl_dropped <= pl_valid && pl_first && !fits;
            rx_overflow <= u_rx_valid && (rcount == RX_FULL);
            parity_err <= u_rx_valid && u_par_err;
            frame_err <= u_rx_valid && u_frm_err;
            link.cts_n <= cts_flow_enable_cmd ? cts_hold : gpio_line_7;
            link.on_sleep <= status_pin_enable ? awake : gpio_line_9;
            link.assoc <= assoc_pin_enable ? associated : gpio_line_5;
            gpio_line_6 <= rts_lvl;
            gpio_line_8 <= sleep_lvl;
            sleep_requested <= sleep_lvl;
            button_pressed <= (btn_lvl == 1'b0);
        end
    end
endmodule : hsp_device

// *** hw/hsp_pkg.sv ***
// Purpose: Shared constants, types and helpers for the host serial port.
// Assumes: One 100 MHz clock on both ends of the link.
// Notes: Start, eight data bits LSB first, optional parity, stop.
package hsp_pkg;
    localparam int unsigned CLK_HZ = 100_000_000;
    localparam int unsigned DEF_BAUD = 9600;
    localparam int DATA_BITS = 8;
    localparam logic [2:0] LAST_BIT = 3'(DATA_BITS - 1);
    localparam logic LINE_IDLE = 1'b1;
    localparam logic START_LVL = 1'b0;
    localparam logic STOP_LVL = 1'b1;
    localparam logic FLOW_GO = 1'b0;
    localparam int CTS_STOP_FREE = 17;
    localparam int CTS_GO_FREE = 34;
    localparam logic [2:0] SYNC_IDLE = 3'h7;

    typedef enum logic [1:0] {
        PAR_NONE = 2'h0,
        PAR_EVEN = 2'h1,
        PAR_ODD = 2'h2
    } hsp_parity_t;

    // Gray codes along idle, start, data, parity, stop.
    typedef enum logic [2:0] {
        ST_IDLE = 3'h0,
        ST_START = 3'h1,
        ST_DATA = 3'h3,
        ST_PAR = 3'h2,
        ST_STOP = 3'h6
    } hsp_bit_state_t;

    // Parity bit that goes with a byte under the chosen mode.
    function automatic logic hsp_parity_bit(input logic [7:0] d, input hsp_parity_t m);
        return (^d) ^ (m == PAR_ODD);
    endfunction : hsp_parity_bit
endpackage : hsp_pkg

// *** hw/hsp_link_if.sv ***
// Purpose: Wire bundle between the radio module and its host.
// Assumes: All pins are driven one way only.
// Notes: Flow-control, status and button pins are active low where named _n.
`timescale 1ns/100ps
interface hsp_link_if;
    logic din;
    logic dout;
    logic cts_n;
    logic rts_n;
    logic sleep_rq;
    logic on_sleep;
    logic assoc;
    logic btn_n;

    modport dev (input din, input rts_n, input sleep_rq, input btn_n,
                 output dout, output cts_n, output on_sleep, output assoc);
    modport host (output din, output rts_n, output sleep_rq, output btn_n,
                  input dout, input cts_n, input on_sleep, input assoc);
endinterface : hsp_link_if

// *** hw/hsp_uart.sv ***
// Purpose: Byte-wide UART transmitter and receiver with parity.
// Assumes: CLKS_PER_BIT is at least 4.
// Notes: The receive pin is synchronised here through three flip-flops.
`timescale 1ns/100ps
module hsp_uart import hsp_pkg::*; #(
    parameter int CLKS_PER_BIT = CLK_HZ / DEF_BAUD
) (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic ce,
    input wire hsp_parity_t parity_mode,
    input wire logic rx_pin,
    output logic tx_pin,
    input wire logic [7:0] tx_data,
    input wire logic tx_valid,
    output logic tx_ready,
    output logic [7:0] rx_data,
    output logic rx_valid,
    output logic rx_parity_err,
    output logic rx_frame_err
);
    localparam int CW = $clog2(CLKS_PER_BIT + 1);
    localparam logic [CW-1:0] FULL = CW'(CLKS_PER_BIT - 1);
    localparam logic [CW-1:0] HALF = CW'(CLKS_PER_BIT / 2 - 1);

    logic [2:0] sync_q;
    logic lvl;
    hsp_bit_state_t rst_q, tst_q;
    logic [CW-1:0] rcnt, tcnt;
    logic [2:0] rbit, tbit;
    logic [7:0] rsh, tsh;
    logic rpar, tpar;
    wire use_par = (parity_mode != PAR_NONE);
    wire r_end = (rcnt == FULL);
    wire t_end = (tcnt == FULL);

    assign tx_ready = ce && (tst_q == ST_IDLE);

    ////////////////////////////////////////////////////////////////////////////
    // Receiver: a change counts once the second and third stages agree.
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            sync_q <= SYNC_IDLE;
            lvl <= LINE_IDLE;
            rst_q <= ST_IDLE;
            rcnt <= '0;
            rbit <= '0;
            rsh <= '0;
            rpar <= 1'b0;
            rx_data <= '0;
            rx_valid <= 1'b0;
            rx_parity_err <= 1'b0;
            rx_frame_err <= 1'b0;
        end else if (ce) begin
            sync_q <= {sync_q[1:0], rx_pin};
            if (sync_q[1] == sync_q[2]) begin
                lvl <= sync_q[2];
            end
            rx_valid <= 1'b0;
            rcnt <= rcnt + 1'b1;
            case (rst_q)
                ST_IDLE: begin
                    rcnt <= '0;
                    if (lvl == START_LVL) begin
                        rst_q <= ST_START;
                    end
                end
                ST_START: begin
                    // Glitches under half a bit are dropped.
                    if (rcnt == HALF) begin
                        rcnt <= '0;
                        rbit <= '0;
                        rst_q <= (lvl == START_LVL) ? ST_DATA : ST_IDLE;
                    end
                end
                ST_DATA: begin
                    if (r_end) begin
                        rcnt <= '0;
                        rsh <= {lvl, rsh[7:1]};
                        rbit <= rbit + 1'b1;
                        if (rbit == LAST_BIT) begin
                            rst_q <= use_par ? ST_PAR : ST_STOP;
                        end
                    end
                end
                ST_PAR: begin
                    if (r_end) begin
                        rcnt <= '0;
                        rpar <= lvl;
                        rst_q <= ST_STOP;
                    end
                end
                ST_STOP: begin
                    if (r_end) begin
                        rst_q <= ST_IDLE;
                        rx_data <= rsh;
                        rx_valid <= 1'b1;
                        rx_frame_err <= (lvl != STOP_LVL);
                        rx_parity_err <= use_par && (rpar != hsp_parity_bit(rsh, parity_mode));
                    end
                end
                default: rst_q <= ST_IDLE;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Transmitter: bit timing derived from the local clock.
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            tst_q <= ST_IDLE;
            tx_pin <= LINE_IDLE;
            tcnt <= '0;
            tbit <= '0;
            tsh <= '0;
            tpar <= 1'b0;
        end else if (ce) begin
            tcnt <= t_end ? '0 : tcnt + 1'b1;
            case (tst_q)
                ST_IDLE: begin
                    tcnt <= '0;
                    if (tx_valid) begin
                        tsh <= tx_data;
                        tpar <= hsp_parity_bit(tx_data, parity_mode);
                        tx_pin <= START_LVL;
                        tst_q <= ST_START;
                    end
                end
                ST_START: begin
                    if (t_end) begin
                        tx_pin <= tsh[0];
                        tbit <= '0;
                        tst_q <= ST_DATA;
                    end
                end
                ST_DATA: begin
                    if (t_end) begin
                        tbit <= tbit + 1'b1;
                        tsh <= {1'b0, tsh[7:1]};
                        if (tbit != LAST_BIT) begin
                            tx_pin <= tsh[1];
                        end else if (use_par) begin
                            tx_pin <= tpar;
                            tst_q <= ST_PAR;
                        end else begin
                            tx_pin <= STOP_LVL;
                            tst_q <= ST_STOP;
                        end
                    end
                end
                ST_PAR: begin
                    if (t_end) begin
                        tx_pin <= STOP_LVL;
                        tst_q <= ST_STOP;
                    end
                end
                ST_STOP: begin
                    if (t_end) begin
                        tst_q <= ST_IDLE;
                    end
                end
                default: tst_q <= ST_IDLE;
            endcase
        end
    end
endmodule : hsp_uart

// *** hw/hsp_host.sv ***
// Purpose: Host end of the serial link, a plain UART with flow-control pins.
// Assumes: Settings match those given to the module end.
// Notes: Status pins from the module are synchronised before use.
`timescale 1ns/100ps
module hsp_host import hsp_pkg::*; #(
    parameter int BAUD = DEF_BAUD
) (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic ce,
    hsp_link_if.host link,
    input wire hsp_parity_t parity_mode,
    input wire logic obey_cts,
    input wire logic [7:0] send_data,
    input wire logic send_valid,
    output logic send_ready,
    output logic [7:0] recv_data,
    output logic recv_valid,
    output logic recv_parity_err,
    output logic recv_frame_err,
    input wire logic hold_module_tx,
    input wire logic sleep_request,
    input wire logic button_closed,
    output logic module_cts_clear,
    output logic module_awake,
    output logic module_associated
);
    localparam int NPIN = 3;

    ////////////////////////////////////////////////////////////////////////////
    // Module status pins pass three flip-flops.
    logic [NPIN-1:0] pin_raw;
    logic [NPIN-1:0] pin_lvl;
    logic [2:0] sync_q [NPIN];
    logic u_tx_ready;

    assign pin_raw = {link.assoc, link.on_sleep, link.cts_n};

    for (genvar i = 0; i < NPIN; i++) begin : g_sync
        always_ff @(posedge ref_clk) begin
            if (!rst_n) begin
                sync_q[i] <= SYNC_IDLE;
                pin_lvl[i] <= LINE_IDLE;
            end else if (ce) begin
                sync_q[i] <= {sync_q[i][1:0], pin_raw[i]};
                if (sync_q[i][1] == sync_q[i][2]) begin
                    pin_lvl[i] <= sync_q[i][2];
                end
            end
        end
    end

    // Clear-to-send high holds new characters, not one in flight.
    wire cts_stop = obey_cts && (pin_lvl[0] != FLOW_GO);
    assign send_ready = u_tx_ready && !cts_stop;

    hsp_uart #(.CLKS_PER_BIT(CLK_HZ / BAUD)) u_uart (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .ce(ce),
        .parity_mode(parity_mode),
        .rx_pin(link.dout),
        .tx_pin(link.din),
        .tx_data(send_data),
        .tx_valid(send_valid && !cts_stop),
        .tx_ready(u_tx_ready),
        .rx_data(recv_data),
        .rx_valid(recv_valid),
        .rx_parity_err(recv_parity_err),
        .rx_frame_err(recv_frame_err)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Registered control pins.
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            link.rts_n <= FLOW_GO;
            link.sleep_rq <= 1'b0;
            link.btn_n <= LINE_IDLE;
            module_cts_clear <= 1'b0;
            module_awake <= 1'b0;
            module_associated <= 1'b0;
        end else if (ce) begin
            link.rts_n <= hold_module_tx ? ~FLOW_GO : FLOW_GO;
            link.sleep_rq <= sleep_request;
            link.btn_n <= ~button_closed;
            module_cts_clear <= (pin_lvl[0] == FLOW_GO);
            module_awake <= pin_lvl[1];
            module_associated <= pin_lvl[2];
        end
    end
endmodule : hsp_host

// *** bench/hsp_link_asserts.sv ***
// Purpose: Wire-level checks on the host serial link.
// Assumes: CPB is the bit period used by both ends.
// Notes: Frame counters restart on every start edge.
`timescale 1ns/100ps
module hsp_link_asserts import hsp_pkg::*; #(
    parameter int CPB = 10
) (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire hsp_parity_t parity_mode,
    input wire logic din,
    input wire logic dout,
    input wire logic cts_n,
    input wire logic rts_n,
    input wire logic sleep_rq,
    input wire logic btn_n
);
    int unsigned fl;
    int unsigned co;
    int unsigned ci;
    // A parity bit stretches the frame by one bit period.
    assign fl = (parity_mode == PAR_NONE) ? 10 * CPB : 11 * CPB;
    // Cycles into the frame, zero when idle.
    always_ff @(posedge ref_clk) begin
        if (!rst_n || co == fl - 1) co <= 0;
        else if (co != 0 || $fell(dout)) co <= co + 1;
        if (!rst_n || ci == fl - 1) ci <= 0;
        else if (ci != 0 || $fell(din)) ci <= ci + 1;
    end
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    sequence s_low8(logic s);
        (!s) [*8];
    endsequence
    chk_out_start_low: assert property ($fell(dout) |-> s_low8(dout))
        else $error("data-out start bit too short");
    chk_in_start_low: assert property ($fell(din) |-> s_low8(din))
        else $error("data-in start bit too short");
    chk_out_stop_high: assert property (co >= fl - CPB |-> dout)
        else $error("data-out stop bit low");
    chk_in_stop_high: assert property (ci >= fl - CPB |-> din)
        else $error("data-in stop bit low");
    chk_out_bit_steady: assert property (co % CPB != 0 |-> $stable(dout))
        else $error("data-out moved inside a bit");
    chk_in_bit_steady: assert property (ci % CPB != 0 |-> $stable(din))
        else $error("data-in moved inside a bit");
    chk_rts_hold_tx: assert property (rts_n [*8] |-> !$fell(dout))
        else $error("character started while held");
    chk_cts_after_reset: assert property ($rose(rst_n) |-> ##[1:2] !cts_n)
        else $error("cts_n not low after reset");
    chk_host_pin_reset: assert property ($rose(rst_n) |-> !rts_n && !sleep_rq && btn_n)
        else $error("host pins wrong after reset");
endmodule : hsp_link_asserts

// *** bench/testbench.sv ***
// Purpose: Self-checking bench joining the module end to the host end.
// Assumes: A ten-cycle bit period keeps the run short.
// Notes: Pulses are sampled on the falling edge, where they are settled.
`timescale 1ns/100ps
module testbench import hsp_pkg::*; ;
    localparam int BAUD = 10_000_000;
    localparam int CPB = CLK_HZ / BAUD;
    logic ref_clk, rst_n, rxb_ready, radio_rx_active, route_busy, pl_valid, pl_first;
    logic status_pin_enable, assoc_pin_enable, awake, associated, send_valid, hold_module_tx;
    logic gpio_line_5, gpio_line_7, gpio_line_9, sleep_request, button_closed, module_awake;
    logic rxb_valid, pl_dropped, rx_overflow, parity_err, frame_err, gpio_line_6, gpio_line_8;
    logic sleep_requested, button_pressed, send_ready, recv_valid, module_associated;
    logic [7:0] pl_data, pl_len, send_data, rxb_data, recv_data;
    logic [7:0] rq[$];
    hsp_parity_t par;
    int checks, fail_count, drops, ovf, errs;
    hsp_link_if link();
    hsp_device #(.BAUD(BAUD)) i_hsp_device (.ref_clk, .rst_n, .ce(1'b1), .link(link.dev),
        .parity_mode(par), .cts_flow_enable_cmd(!hold_module_tx), .rts_flow_enable_cmd(1'b1),
        .status_pin_enable, .assoc_pin_enable, .rxb_data, .rxb_valid, .rxb_ready,
        .radio_rx_active, .route_busy, .pl_data, .pl_valid, .pl_first, .pl_len, .pl_ready(),
        .pl_dropped, .rx_overflow, .parity_err, .frame_err, .awake, .associated, .gpio_line_5,
        .gpio_line_7, .gpio_line_9, .gpio_line_6, .gpio_line_8, .sleep_requested,
        .button_pressed);
    hsp_host #(.BAUD(BAUD)) i_hsp_host (.ref_clk, .rst_n, .ce(1'b1), .link(link.host),
        .parity_mode(par), .obey_cts(1'b0), .send_data, .send_valid, .send_ready, .recv_data,
        .recv_valid, .recv_parity_err(), .recv_frame_err(), .hold_module_tx, .sleep_request,
        .button_closed, .module_cts_clear(), .module_awake, .module_associated);
    hsp_link_asserts #(.CPB(CPB)) i_hsp_link_asserts (.ref_clk, .rst_n, .parity_mode(par),
        .din(link.din), .dout(link.dout), .cts_n(link.cts_n), .rts_n(link.rts_n),
        .sleep_rq(link.sleep_rq), .btn_n(link.btn_n));
    ////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checks++;
        if (got !== exp) begin
            fail_count++;
            $display("unexpected at %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    task automatic cyc(input int n);
        repeat (n) @(negedge ref_clk);
    endtask : cyc
    // Held until the edge that takes it.
    task automatic send(input logic [7:0] b);
        int n;
        @(negedge ref_clk);
        send_data = b;
        send_valid = 1'b1;
        for (n = 0; n < 500 && send_ready !== 1'b1; n++) @(negedge ref_clk);
        @(negedge ref_clk);
        send_valid = 1'b0;
    endtask : send
    task automatic pop(input logic [7:0] exp);
        int n;
        for (n = 0; n < 500 && rxb_valid !== 1'b1; n++) @(negedge ref_clk);
        chk(rxb_data, exp);
        rxb_ready = 1'b1;
        @(negedge ref_clk);
        rxb_ready = 1'b0;
        @(negedge ref_clk);
    endtask : pop
    task automatic pl_send(input int len, input logic [7:0] base);
        for (int k = 0; k < len; k++) begin
            @(negedge ref_clk);
            pl_valid = 1'b1;
            pl_first = (k == 0);
            pl_len = 8'(len);
            pl_data = base + 8'(k);
        end
        @(negedge ref_clk);
        pl_valid = 1'b0;
    endtask : pl_send
    task automatic conclude();
        $display("checks %0d fail_count %0d", checks, fail_count);
        if (fail_count == 0 && checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : conclude
    ////////////////////////////////////////////////////////////////////////
    // One-cycle pulses are tallied, not polled.
    always @(negedge ref_clk) begin
        if (pl_dropped === 1'b1) drops++;
        if (rx_overflow === 1'b1) ovf++;
        if (parity_err === 1'b1 || frame_err === 1'b1) errs++;
        if (recv_valid === 1'b1) rq.push_back(recv_data);
    end
    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end
    // Roughly 2.5 times the expected run.
    initial begin
        repeat (60000) @(posedge ref_clk);
        fail_count++;
        conclude();
    end
    initial begin
        {rst_n, rxb_ready, radio_rx_active, route_busy, pl_valid, pl_first} = 6'h00;
        {status_pin_enable, assoc_pin_enable, awake, associated, send_valid} = 5'h00;
        {hold_module_tx, gpio_line_5, gpio_line_7, gpio_line_9} = 4'h0;
        {sleep_request, button_closed, pl_data, pl_len, send_data} = 26'h0;
        par = PAR_NONE;
        cyc(12);
        rst_n = 1'b1;
        // Each parity mode, drain held off.
        for (int m = 0; m < 3; m++) begin
            par = hsp_parity_t'(m);
            radio_rx_active = 1'b1;
            send(8'h1f + 8'(m));
            cyc(150);
            chk(rxb_valid, 8'h00);
            radio_rx_active = 1'b0;
            route_busy = 1'b1;
            cyc(2);
            chk(rxb_valid, 8'h00);
            route_busy = 1'b0;
            pop(8'h1f + 8'(m));
        end
        chk(8'(errs), 8'h00);
        $display("test formats done");
        // Fill the receive buffer past full, then drain it.
        radio_rx_active = 1'b1;
        for (int i = 0; i < 65; i++) begin
            send(8'(i));
            if (i == 45 || i == 46) begin
                cyc(120);
                chk(link.cts_n, 8'(i == 46));
            end
        end
        cyc(120);
        chk(8'(ovf), 8'h01);
        radio_rx_active = 1'b0;
        for (int i = 0; i < 64; i++) begin
            pop(8'(i));
            if (i == 32 || i == 33) begin
                cyc(3);
                chk(link.cts_n, 8'(i == 32));
            end
        end
        chk(rxb_valid, 8'h00);
        $display("test flow done");
        // Alternate pin uses.
        for (int v = 0; v < 2; v++) begin
            {sleep_request, button_closed, hold_module_tx, awake} = {4{v[0]}};
            {status_pin_enable, assoc_pin_enable, gpio_line_5, gpio_line_7} = {4{v[0]}};
            {gpio_line_9, associated} = {2{!v[0]}};
            cyc(20);
            chk({sleep_requested, gpio_line_8, button_pressed}, {3{v[0]}});
            chk({gpio_line_6, link.rts_n, link.cts_n}, {3{v[0]}});
            chk({module_awake, link.assoc}, 8'h02);
        end
        $display("test pins done");
        // Payloads queue while held; one is dropped whole.
        pl_send(100, 8'h00);
        pl_send(50, 8'h40);
        pl_send(28, 8'h80);
        cyc(200);
        chk(8'(drops), 8'h01);
        chk(8'(rq.size()), 8'h00);
        hold_module_tx = 1'b0;
        cyc(14400);
        chk(8'(rq.size()), 8'h80);
        for (int i = 0; i < 128; i++) chk(rq[i], (i < 100) ? 8'(i) : 8'(i + 28));
        $display("test payloads done");
        conclude();
    end
endmodule : testbench
